// ### rtl/atr_derivative.sv
`timescale 1ns/1ns
module atr_derivative #(
	parameter int unsigned WIDTH = atr_pkg::DATA_W
) (
	// Clock and reset
	input  logic             mclk,
	input  logic             rst_n,
	// Sample input
	input  logic             sample_en,
	input  logic [WIDTH-1:0] din,
	// Difference output
	output logic [WIDTH-1:0] dout,
	output logic             done
);
	import atr_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] prev;
		logic [WIDTH-1:0] diff;
		logic             primed;
		logic             done;
	} atr_dv_s;

	atr_dv_s state_reg;
	atr_dv_s state_next;

	always_comb begin
		state_next      = state_reg;
		state_next.done = sample_en;
		if (sample_en) begin
			// Modulo difference so an angle wrap reads as a small step
			state_next.diff   = state_reg.primed ? WIDTH'(din - state_reg.prev) : '0;
			state_next.prev   = din;
			state_next.primed = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign dout = state_reg.diff;
	assign done = state_reg.done;

	chk_diff_value: assert property (@(posedge mclk) disable iff (!rst_n)
		(sample_en && state_reg.primed) |=> (done && dout == WIDTH'($past(din) - $past(state_reg.prev))))
		else $error("derivative output wrong");

endmodule

// ### rtl/atr_pkg.sv
package atr_pkg;

	// Register port geometry
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 16;

	// Register offsets
	localparam logic [5:0] ADDR_PRIMARY_ANGLE         = 6'h10;
	localparam logic [5:0] ADDR_PRIMARY_TEMPERATURE   = 6'h13;
	localparam logic [5:0] ADDR_FIELD_MAGNITUDE       = 6'h14;
	localparam logic [5:0] ADDR_PRIMARY_TURNS_COUNTER = 6'h15;
	localparam logic [5:0] ADDR_HYSTERESIS_ANGLE      = 6'h16;
	localparam logic [5:0] ADDR_PRIMARY_VELOCITY      = 6'h17;
	localparam logic [5:0] ADDR_PRIMARY_ACCELERATION  = 6'h18;
	localparam logic [5:0] ADDR_SECONDARY_ANGLE       = 6'h19;

	// Field layout
	localparam int unsigned TEMP_W    = 12;
	localparam int unsigned TURNS_W   = 11;
	localparam int unsigned WARN_BIT  = 13;
	localparam int unsigned OVF_BIT   = 12;
	localparam int unsigned HYST_W    = 3;
	localparam int unsigned QUAD_MSB  = 15;
	localparam int unsigned QUAD_LSB  = 14;

	// Reset values
	localparam logic [15:0] RESET_DATA = 16'h0000;

	// Angle LSBs per step of the hysteresis setting
	localparam logic [15:0] HYST_STEP = 16'h0010;

	// Timing
	localparam int unsigned CLK_PERIOD_NS    = 40;
	localparam int unsigned DERIV_PERIOD_NS  = 32000;
	localparam int unsigned DERIV_PERIOD_CYC = DERIV_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		BIST_IDLE,
		BIST_FORCE,
		BIST_CHECK
	} atr_bist_e;

endpackage

// ### rtl/atr_readout.sv
`timescale 1ns/1ns
module atr_readout #(
	parameter int unsigned DERIV_CYC = atr_pkg::DERIV_PERIOD_CYC
) (
	// Clock and reset
	input  logic                       mclk,
	input  logic                       rst_n,
	// Register port
	input  logic [atr_pkg::ADDR_W-1:0] reg_addr,
	input  logic                       reg_rd,
	input  logic                       reg_wr,
	input  logic [atr_pkg::DATA_W-1:0] reg_wdata,
	output logic [atr_pkg::DATA_W-1:0] reg_rdata,
	output logic                       reg_rvalid,
	// Measurements from the signal path
	input  logic [atr_pkg::TEMP_W-1:0] temp_code,
	input  logic [15:0]                field_amplitude,
	input  logic [15:0]                primary_angle,
	input  logic [15:0]                secondary_angle_in,
	input  logic [15:0]                encoder_source_angle,
	// Configuration and commands
	input  logic [atr_pkg::HYST_W-1:0] hysteresis_setting,
	input  logic                       turns_count_reset,
	input  logic                       low_power,
	// Fault flags
	input  logic                       primary_voltage_check_fault,
	input  logic                       oscillator_fault,
	input  logic                       supply_undervoltage,
	input  logic                       low_power_turns_fault,
	// Turns status
	output logic                       primary_turns_warning,
	output logic                       primary_turns_overflow,
	output logic                       secondary_turns_warning,
	output logic                       secondary_turns_overflow,
	output logic                       latched_secondary_turns_warning,
	// Latched copies
	output logic [15:0]                latched_secondary_angle,
	output logic [15:0]                latched_primary_turns,
	output logic [15:0]                latched_secondary_turns
);
	import atr_pkg::*;

	localparam int unsigned TICK_W = (DERIV_CYC > 1) ? $clog2(DERIV_CYC) : 1;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(DERIV_CYC - 1);

	typedef struct packed {
		logic [15:0]       temp;
		logic [15:0]       field;
		logic [15:0]       hyst;
		logic [15:0]       secondary_angle;
		logic [TICK_W-1:0] tick_cnt;
		logic              tick;
		atr_bist_e         bist;
		logic              bist_fail;
		logic              lp_fault;
		logic              lp_prev;
		logic              warn_p;
		logic              warn_s;
		logic              warn_latch_s;
		logic [15:0]       lat_secondary_angle;
		logic [15:0]       lat_p_turns;
		logic [15:0]       lat_s_turns;
		logic [15:0]       rdata;
		logic              rvalid;
	} atr_top_s;

	atr_top_s             state_reg;
	atr_top_s             state_next;
	logic [TURNS_W-1:0]   p_count;
	logic [TURNS_W-1:0]   s_count;
	logic                 p_ovf;
	logic                 s_ovf;
	logic                 p_test_ok;
	logic                 s_test_ok;
	logic                 test_en;
	logic [15:0]          velocity;
	logic                 vel_done;
	logic [15:0]          acceleration;
	logic                 acc_done;
	logic [15:0]          p_word;
	logic [15:0]          s_word;
	logic [15:0]          hyst_diff;
	logic [15:0]          hyst_mag;
	logic [15:0]          hyst_thr;
	logic                 hyst_move;
	logic                 lp_exit;
	logic                 warn_cause;

	assign test_en = (state_reg.bist == BIST_FORCE);

	atr_turns_counter #(
		.COUNT_W (TURNS_W)
	) u_primary_turns (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.quadrant (primary_angle[QUAD_MSB:QUAD_LSB]),
		.clear    (turns_count_reset),
		.test_en  (test_en),
		.count    (p_count),
		.overflow (p_ovf),
		.test_ok  (p_test_ok)
	);

	atr_turns_counter #(
		.COUNT_W (TURNS_W)
	) u_secondary_turns (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.quadrant (secondary_angle_in[QUAD_MSB:QUAD_LSB]),
		.clear    (turns_count_reset),
		.test_en  (test_en),
		.count    (s_count),
		.overflow (s_ovf),
		.test_ok  (s_test_ok)
	);

	atr_derivative #(
		.WIDTH (16)
	) u_velocity (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sample_en (state_reg.tick),
		.din       (primary_angle),
		.dout      (velocity),
		.done      (vel_done)
	);

	// Chained off velocity so both use the same sample spacing
	atr_derivative #(
		.WIDTH (16)
	) u_acceleration (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sample_en (vel_done),
		.din       (velocity),
		.dout      (acceleration),
		.done      (acc_done)
	);

	always_comb begin
		state_next = state_reg;
		p_word     = RESET_DATA;
		s_word     = RESET_DATA;

		// Measurement snapshots
		state_next.temp      = {4'h0, temp_code};
		state_next.field     = field_amplitude;
		state_next.secondary_angle = secondary_angle_in;

		// Sample tick for the derivatives
		state_next.tick     = (state_reg.tick_cnt == TICK_LAST);
		state_next.tick_cnt = state_next.tick ? '0 : TICK_W'(state_reg.tick_cnt + 1'b1);

		// Hysteresis: follow only once the move exceeds the threshold
		hyst_diff = 16'(encoder_source_angle - state_reg.hyst);
		hyst_mag  = hyst_diff[15] ? 16'(~hyst_diff + 16'h0001) : hyst_diff;
		hyst_thr  = 16'(HYST_STEP * {13'h0000, hysteresis_setting});
		hyst_move = (hyst_mag > hyst_thr);
		if (hyst_move) begin
			state_next.hyst = encoder_source_angle;
		end

		// Stuck-at-zero test of the counter inputs
		state_next.lp_prev = low_power;
		lp_exit            = state_reg.lp_prev & ~low_power;
		case (state_reg.bist)
			BIST_FORCE: begin
				state_next.bist = BIST_CHECK;
			end
			BIST_CHECK: begin
				if (!(p_test_ok && s_test_ok)) begin
					state_next.bist_fail = 1'b1;
				end
				state_next.bist = BIST_IDLE;
			end
			default: begin
				state_next.bist = BIST_IDLE;
			end
		endcase
		if (lp_exit) begin
			state_next.bist = BIST_FORCE;
		end

		// Tracking may be lost while asleep; held until reset
		if (low_power && low_power_turns_fault) begin
			state_next.lp_fault = 1'b1;
		end

		warn_cause = primary_voltage_check_fault | oscillator_fault | supply_undervoltage
			| state_next.lp_fault | state_next.bist_fail;
		state_next.warn_p = warn_cause;
		state_next.warn_s = warn_cause;

		// Turns register words
		p_word[WARN_BIT]      = state_reg.warn_p;
		p_word[OVF_BIT]       = p_ovf;
		p_word[TURNS_W-1:0]   = p_count;
		s_word[WARN_BIT]      = state_reg.warn_s;
		s_word[OVF_BIT]       = s_ovf;
		s_word[TURNS_W-1:0]   = s_count;

		// Read port; writes have no path into any state
		state_next.rvalid = reg_rd;
		state_next.rdata  = RESET_DATA;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_PRIMARY_TEMPERATURE:   state_next.rdata = state_reg.temp;
				ADDR_FIELD_MAGNITUDE:       state_next.rdata = state_reg.field;
				ADDR_PRIMARY_TURNS_COUNTER: state_next.rdata = p_word;
				ADDR_HYSTERESIS_ANGLE:      state_next.rdata = state_reg.hyst;
				ADDR_PRIMARY_VELOCITY:      state_next.rdata = velocity;
				ADDR_PRIMARY_ACCELERATION:  state_next.rdata = acceleration;
				ADDR_SECONDARY_ANGLE:       state_next.rdata = state_reg.secondary_angle;
				default:                    state_next.rdata = RESET_DATA;
			endcase
			if (reg_addr == ADDR_PRIMARY_ANGLE) begin
				state_next.lat_secondary_angle = state_reg.secondary_angle;
				state_next.lat_p_turns   = p_word;
				state_next.lat_s_turns   = s_word;
				state_next.warn_latch_s  = state_reg.warn_s;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg      <= '0;
			state_reg.bist <= BIST_FORCE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata                       = state_reg.rdata;
	assign reg_rvalid                      = state_reg.rvalid;
	assign primary_turns_warning           = state_reg.warn_p;
	assign primary_turns_overflow          = p_ovf;
	assign secondary_turns_warning         = state_reg.warn_s;
	assign secondary_turns_overflow        = s_ovf;
	assign latched_secondary_turns_warning = state_reg.warn_latch_s;
	assign latched_secondary_angle         = state_reg.lat_secondary_angle;
	assign latched_primary_turns           = state_reg.lat_p_turns;
	assign latched_secondary_turns         = state_reg.lat_s_turns;

	chk_temp_read_value: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_PRIMARY_TEMPERATURE)
		|=> (reg_rdata == {4'h0, $past(temp_code, 2)}))
		else $error("temperature read value wrong");

	chk_field_read_value: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_FIELD_MAGNITUDE) |=> (reg_rdata == $past(field_amplitude, 2)))
		else $error("field read value wrong");

	chk_turns_read_word: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_PRIMARY_TURNS_COUNTER)
		|=> (reg_rdata[15:14] == 2'b00 && reg_rdata[11] == 1'b0
		&& reg_rdata[WARN_BIT] == $past(primary_turns_warning)
		&& reg_rdata[OVF_BIT] == $past(primary_turns_overflow)
		&& reg_rdata[TURNS_W-1:0] == $past(p_count)))
		else $error("turns counter word wrong");

	chk_warn_fault_cause: assert property (@(posedge mclk) disable iff (!rst_n)
		(primary_voltage_check_fault || oscillator_fault || supply_undervoltage)
		|=> primary_turns_warning)
		else $error("warning missing on fault");

	chk_lp_fault_warn: assert property (@(posedge mclk) disable iff (!rst_n)
		(low_power && low_power_turns_fault) |=> primary_turns_warning [*8])
		else $error("low-power fault warning not held");

	chk_bist_restart: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(low_power) |=> (state_reg.bist == BIST_FORCE) ##1 (state_reg.bist == BIST_CHECK))
		else $error("test not run after low-power exit");

	chk_bist_fail_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(state_reg.bist_fail) |-> (primary_turns_warning && secondary_turns_warning) [*8])
		else $error("test failure warning not held");

	chk_ovf_hold_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		(primary_turns_overflow && !turns_count_reset) |=> primary_turns_overflow)
		else $error("overflow dropped without reset command");

	chk_hyst_hold_value: assert property (@(posedge mclk) disable iff (!rst_n)
		!hyst_move |=> $stable(state_reg.hyst))
		else $error("hysteresis angle moved inside band");

	chk_accel_follows_vel: assert property (@(posedge mclk) disable iff (!rst_n)
		vel_done |=> acc_done)
		else $error("acceleration not updated after velocity");

	chk_warn_redundant: assert property (@(posedge mclk) disable iff (!rst_n)
		primary_turns_warning == secondary_turns_warning)
		else $error("redundant warnings differ");

	chk_latch_on_angle: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_PRIMARY_ANGLE)
		|=> (latched_secondary_angle == $past(state_reg.secondary_angle)
		&& latched_secondary_turns_warning == $past(secondary_turns_warning)))
		else $error("latched copies not captured");

	chk_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_wr && !reg_rd) |=> (!reg_rvalid && $stable(state_reg.lat_secondary_angle)))
		else $error("write had an effect");

endmodule

// ### rtl/atr_turns_counter.sv
`timescale 1ns/1ns
module atr_turns_counter #(
	parameter int unsigned COUNT_W = atr_pkg::TURNS_W
) (
	// Clock and reset
	input  logic               mclk,
	input  logic               rst_n,
	// Angle quadrant and commands
	input  logic [1:0]         quadrant,
	input  logic               clear,
	input  logic               test_en,
	// Results
	output logic [COUNT_W-1:0] count,
	output logic               overflow,
	output logic               test_ok
);
	import atr_pkg::*;

	localparam logic [COUNT_W-1:0] CNT_MAX = {1'b0, {(COUNT_W-1){1'b1}}};
	localparam logic [COUNT_W-1:0] CNT_MIN = {1'b1, {(COUNT_W-1){1'b0}}};
	localparam logic [COUNT_W-1:0] ONES    = {COUNT_W{1'b1}};

	typedef struct packed {
		logic [1:0]         quad;
		logic [COUNT_W-1:0] count;
		logic               ovf;
		logic [COUNT_W-1:0] cap;
		logic               primed;
	} atr_tc_s;

	atr_tc_s state_reg;
	atr_tc_s state_next;
	logic    step_up;
	logic    step_dn;
	logic    set_ovf;

	always_comb begin
		state_next = state_reg;
		step_up    = (quadrant == 2'(state_reg.quad + 2'h1));
		step_dn    = (quadrant == 2'(state_reg.quad - 2'h1));
		set_ovf    = 1'b0;
		// Test drives all ones through the counter input path; count is held
		state_next.cap = test_en ? ONES : '0;
		if (test_en) begin
			state_next.quad = state_reg.quad;
		end else if (!state_reg.primed) begin
			// First quadrant is the zero reference
			state_next.primed = 1'b1;
			state_next.quad   = quadrant;
		end else begin
			state_next.quad = quadrant;
			if (step_up) begin
				state_next.count = COUNT_W'(state_reg.count + 1'b1);
				set_ovf          = (state_reg.count == CNT_MAX);
			end else if (step_dn) begin
				state_next.count = COUNT_W'(state_reg.count - 1'b1);
				set_ovf          = (state_reg.count == CNT_MIN);
			end
		end
		if (clear) begin
			state_next.count = '0;
		end
		// A new overflow wins over the reset command
		state_next.ovf = set_ovf | (state_reg.ovf & ~clear);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign count    = state_reg.count;
	assign overflow = state_reg.ovf;
	assign test_ok  = (state_reg.cap == ONES);

	chk_ovf_on_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_reg.primed && !test_en && step_up && state_reg.count == CNT_MAX) |=> overflow)
		else $error("overflow not set at positive limit");

endmodule

// ### sim/atr_host_model.sv
`timescale 1ns/1ns
module atr_host_model (
	// Clock
	input  wire logic                  mclk,
	// Register bus toward the device
	output logic [atr_pkg::ADDR_W-1:0] reg_addr,
	output logic                       reg_rd,
	output logic                       reg_wr,
	output logic [atr_pkg::DATA_W-1:0] reg_wdata,
	// Special command
	output logic                       turns_count_reset
);
	import atr_pkg::*;

	initial begin
		reg_addr = '0;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = '0;
		turns_count_reset = 1'b0;
	end

	// Strobe stays up so a following read makes a back-to-back burst
	task automatic read(input logic [ADDR_W-1:0] addr);
		@(negedge mclk);
		reg_addr = addr;
		reg_rd = 1'b1;
	endtask

	task automatic write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		@(negedge mclk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
	endtask

	task automatic turns_reset();
		@(negedge mclk);
		turns_count_reset = 1'b1;
	endtask

	// Idle address and data lines toggle so a stale value is never mistaken for a driven one
	task automatic idle(input int cycles);
		repeat (cycles) begin
			@(negedge mclk);
			reg_rd = 1'b0;
			reg_wr = 1'b0;
			turns_count_reset = 1'b0;
			reg_addr = ~reg_addr;
			reg_wdata = ~reg_wdata;
		end
	endtask
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
	import atr_pkg::*;
	localparam int unsigned DCYC = 8;

	logic mclk, rst_n, rvalid, lp, lp_fault, ovf_s, warn_l;
	logic [5:0] addr;
	logic rd, wr, tcr, warn_p, warn_s, ovf_p;
	logic [15:0] wdata, rdata, fld, pang, sang, enc, l_ang, l_pt, l_st;
	logic [11:0] temp;
	logic [2:0] hyst, faults;
	logic [15:0] lfsr, base, band, exp_q[$];
	int num_errors, total_checks;

	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	atr_host_model u_host (.mclk(mclk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
		.reg_wdata(wdata), .turns_count_reset(tcr));

	atr_readout #(.DERIV_CYC(DCYC)) DUT (
		.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .temp_code(temp),
		.field_amplitude(fld), .primary_angle(pang), .secondary_angle_in(sang),
		.encoder_source_angle(enc), .hysteresis_setting(hyst), .turns_count_reset(tcr),
		.low_power(lp), .primary_voltage_check_fault(faults[0]),
		.oscillator_fault(faults[1]), .supply_undervoltage(faults[2]),
		.low_power_turns_fault(lp_fault), .primary_turns_warning(warn_p),
		.primary_turns_overflow(ovf_p), .secondary_turns_warning(warn_s),
		.secondary_turns_overflow(ovf_s), .latched_secondary_turns_warning(warn_l),
		.latched_secondary_angle(l_ang), .latched_primary_turns(l_pt),
		.latched_secondary_turns(l_st));

	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic rd_reg(input logic [5:0] a, input logic [15:0] exp, input bit burst);
		exp_q.push_back(exp);
		u_host.read(a);
		if (!burst) begin
			u_host.idle(2);
		end
	endtask

	task automatic ramp(input logic [15:0] step, input int n);
		repeat (n) begin
			@(negedge mclk);
			pang = pang + step;
			// Secondary follows whole quadrant steps only
			sang = sang + {step[15:14], 14'h0000};
		end
	endtask

	task automatic reset_dut();
		@(negedge mclk);
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		u_host.idle(5);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Answer watcher: every read answer is paired with the oldest note
	always @(negedge mclk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("wrong value read answer expected none seen %h", rdata);
			end else begin
				check("read data", exp_q.pop_front(), rdata);
			end
			check("secondary warning", {15'h0, warn_p}, {15'h0, warn_s});
		end
	end

	initial begin
		repeat (100000) @(posedge mclk);
		num_errors++;
		$display("wrong value run length expected finish seen timeout");
		complete_run();
	end

	initial begin
		int i;
		lfsr = 16'h3DB0;
		rst_n = 1'b0;
		{temp, fld, pang, sang, enc, hyst, faults, lp, lp_fault} = '0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		u_host.idle(5);

		// Measurement words, back-to-back reads, ignored write, unmapped place
		for (i = 0; i < 4; i++) begin
			@(negedge mclk);
			temp = lfsr[11:0];
			lfsr = lfsr_next(lfsr);
			fld = lfsr;
			lfsr = lfsr_next(lfsr);
			// Quadrant held at zero so the secondary count tracks the primary ramp
			sang = lfsr & 16'h3FFF;
			lfsr = lfsr_next(lfsr);
			u_host.idle(3);
			rd_reg(ADDR_PRIMARY_TEMPERATURE, {4'h0, temp}, 1'b1);
			rd_reg(ADDR_FIELD_MAGNITUDE, fld, 1'b1);
			rd_reg(ADDR_SECONDARY_ANGLE, sang, 1'b0);
			u_host.write(ADDR_PRIMARY_TEMPERATURE, lfsr);
			u_host.write(ADDR_SECONDARY_ANGLE, ~sang);
			u_host.idle(1);
			rd_reg(ADDR_PRIMARY_TEMPERATURE, {4'h0, temp}, 1'b0);
			rd_reg(ADDR_SECONDARY_ANGLE, sang, 1'b0);
		end
		rd_reg({1'b1, lfsr[4:0]}, 16'h0000, 1'b0);
		$display("test readout done");

		// Hysteresis band of setting times step, both directions
		@(negedge mclk);
		hyst = lfsr[2:0];
		band = 16'(HYST_STEP * hyst);
		base = {2'b01, lfsr[15:2]};
		lfsr = lfsr_next(lfsr);
		enc = base;
		u_host.idle(3);
		rd_reg(ADDR_HYSTERESIS_ANGLE, base, 1'b0);
		enc = 16'(base + band);
		u_host.idle(3);
		rd_reg(ADDR_HYSTERESIS_ANGLE, base, 1'b0);
		enc = 16'(base + band + 16'h0001);
		u_host.idle(3);
		rd_reg(ADDR_HYSTERESIS_ANGLE, enc, 1'b0);
		enc = base;
		u_host.idle(3);
		rd_reg(ADDR_HYSTERESIS_ANGLE, base, 1'b0);
		$display("test hysteresis done");

		// Steady ramps give steady velocity and zero acceleration
		ramp(16'h0001, 5 * DCYC);
		rd_reg(ADDR_PRIMARY_VELOCITY, 16'(DCYC), 1'b1);
		rd_reg(ADDR_PRIMARY_ACCELERATION, 16'h0000, 1'b0);
		ramp(16'h0002, 5 * DCYC);
		rd_reg(ADDR_PRIMARY_VELOCITY, 16'(2 * DCYC), 1'b0);
		pang = 16'h0000;
		ramp(16'h0000, 5 * DCYC);
		$display("test derivatives done");

		// Quarter turns up to the positive end, then past it
		ramp(16'h4000, 1023);
		u_host.idle(2);
		rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h03FF, 1'b0);
		ramp(16'h4000, 1);
		u_host.idle(2);
		rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h1400, 1'b0);
		check("primary overflow", 16'h0001, {15'h0, ovf_p});
		check("secondary overflow", 16'h0001, {15'h0, ovf_s});
		u_host.idle(20);
		rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h1400, 1'b0);
		rd_reg(ADDR_PRIMARY_ANGLE, 16'h0000, 1'b0);
		check("latched primary turns", 16'h1400, l_pt);
		check("latched secondary angle", sang, l_ang);
		check("latched secondary turns", 16'h1400, l_st);
		sang = ~sang;
		u_host.idle(3);
		check("latched secondary angle", ~sang, l_ang);
		rd_reg(ADDR_SECONDARY_ANGLE, sang, 1'b0);
		u_host.turns_reset();
		u_host.idle(2);
		rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h0000, 1'b0);
		check("primary overflow", 16'h0000, {15'h0, ovf_p});
		check("secondary overflow", 16'h0000, {15'h0, ovf_s});
		ramp(16'hC000, 1);
		u_host.idle(2);
		rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h07FF, 1'b0);
		$display("test turns done");

		// Each awake fault cause raises the warning, which follows it back down; a sleep fault holds it until reset
		// Last pass mixes causes; the sleep fault is ignored while awake
		for (i = 0; i < 4; i++) begin
			@(negedge mclk);
			faults = (i == 3) ? (lfsr[2:0] | 3'h1) : 3'(1 << i);
			lp_fault = lfsr[3];
			lfsr = lfsr_next(lfsr);
			u_host.idle(3);
			rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h27FF, 1'b0);
			faults = 3'h0;
			u_host.idle(3);
			rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h07FF, 1'b0);
		end
		lp_fault = 1'b0;
		lp = 1'b1;
		u_host.idle(3);
		lp = 1'b0;
		u_host.idle(6);
		rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h07FF, 1'b0);
		lp = 1'b1;
		lp_fault = 1'b1;
		u_host.idle(2);
		lp_fault = 1'b0;
		lp = 1'b0;
		u_host.idle(6);
		rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h27FF, 1'b0);
		check("latched warning", 16'h0000, {15'h0, warn_l});
		rd_reg(ADDR_PRIMARY_ANGLE, 16'h0000, 1'b0);
		check("latched warning", 16'h0001, {15'h0, warn_l});
		reset_dut();
		rd_reg(ADDR_PRIMARY_TURNS_COUNTER, 16'h0000, 1'b0);
		$display("test warnings done");

		for (i = 0; i < 10 && exp_q.size() > 0; i++) begin
			@(negedge mclk);
		end
		if (exp_q.size() > 0) begin
			num_errors++;
			$display("wrong value pending answers expected 0 seen %0d", exp_q.size());
		end
		complete_run();
	end
endmodule
